// ==== scl_pkg.sv ====
// package: register map, field layout and constants of the solenoid current loop
package scl_pkg;
  // ****************************************
  // widths
  // ****************************************
  localparam int NCH = 2;
  localparam int AW  = 4;
  localparam int DW  = 16;
  localparam int IW  = 20;

  // ****************************************
  // register offsets (per channel: base + 4*ch, channel status base + ch)
  // ****************************************
  localparam logic [AW-1:0] OFS_TARGET  = 4'h0;
  localparam logic [AW-1:0] OFS_DITHER  = 4'h1;
  localparam logic [AW-1:0] OFS_PERIOD  = 4'h2;
  localparam logic [AW-1:0] OFS_OFFSET  = 4'h3;
  localparam logic [AW-1:0] OFS_PRESC   = 4'h8;
  localparam logic [AW-1:0] OFS_FAULT   = 4'h9;
  localparam logic [AW-1:0] OFS_CHSTAT  = 4'ha;

  // ****************************************
  // target register fields
  // ****************************************
  localparam int TGT_W     = 11;
  localparam int TGT_EN    = 15;
  localparam int TGT_CLAMP = 14;

  // ****************************************
  // dither register fields
  // ****************************************
  localparam int DIT_STEP_LSB = 0;
  localparam int DIT_STEP_W   = 5;
  localparam int DIT_INC_LSB  = 5;
  localparam int DIT_INC_W    = 5;
  localparam int DIT_ALIGN    = 14;
  localparam int DIT_EN       = 15;

  // ****************************************
  // prescaler fields: step time = (n+1)*(m+1) clocks
  // ****************************************
  localparam int PRE_N_LSB = 0;
  localparam int PRE_M_LSB = 8;
  localparam int PRE_W     = 8;

  // ****************************************
  // loop constants
  // ****************************************
  localparam logic [IW-1:0]  CLAMP_LIM   = 20'd20;
  localparam logic [IW-1:0]  NORM_LIM    = 20'h3ffff;
  localparam logic [IW-1:0]  THR_RESET   = 20'h00400;
  localparam logic [3:0]     MISS_CYC    = 4'd8;
  localparam logic [DW-1:0]  PERIOD_RST  = 16'h0040;
  localparam logic [DW-1:0]  PRESC_RST   = 16'h0000;
  localparam logic [DW-1:0]  DITHER_RST  = 16'h0000;
  localparam logic [DW-1:0]  TARGET_RST  = 16'h0000;

  typedef enum logic [1:0] {SCL_OFF, SCL_DRIVE, SCL_RECIRC} scl_phase_e;
  typedef enum logic [1:0] {SCL_D_IDLE, SCL_D_UP, SCL_D_DOWN, SCL_D_WAIT} scl_dith_e;
endpackage : scl_pkg

// ==== scl_chan_if.sv ====
// interface: per-channel settings and status between loop and channel core
`timescale 1ns/1ps
interface scl_chan_if;
  import scl_pkg::*;
  logic [DW-1:0]    target;
  logic [DW-1:0]    dither;
  logic [DW-1:0]    period;
  logic [DW-1:0]    offset;
  logic [DW-1:0]    presc;
  logic             en_pin;
  logic             tgt_wr;
  logic [TGT_W-1:0] isense;
  logic             drive;
  logic             recirc;
  logic             miss;
  logic [DW-1:0]    status;
  modport top  (output target, dither, period, offset, presc, en_pin, tgt_wr, isense,
                input drive, recirc, miss, status);
  modport core (input target, dither, period, offset, presc, en_pin, tgt_wr, isense,
                output drive, recirc, miss, status);
endinterface : scl_chan_if

// ==== scl_chan.sv ====
// one channel: dither generator, error integrator, period controller, switch control
`timescale 1ns/1ps
module scl_chan
  import scl_pkg::*;
(
  input wire logic clk,          // system clock
  input wire logic rst,          // async reset
  scl_chan_if.core ch            // settings and status
);
  typedef struct packed {
    scl_phase_e        phase;
    scl_dith_e         dst;
    logic [DW-1:0]     dit_cfg;
    logic [DW-1:0]     pre_cnt;
    logic [4:0]        step_cnt;
    logic [IW-1:0]     dval;
    logic signed [IW:0] integ;
    logic [IW-1:0]     thr;
    logic [DW-1:0]     per_cnt;
    logic              pwm_start;
    logic              pwm_seen;
    logic              clamp_act;
    logic [3:0]        miss_cnt;
    logic              miss_arm;
    logic              miss;
  } scl_chan_s;

  scl_chan_s q;
  scl_chan_s next_q;

  logic enabled;
  logic [IW-1:0] work;
  logic [IW-1:0] lim;
  logic [DW-1:0] step_len;
  logic [DW-1:0] step_per;
  logic [DW-1:0] m1;
  logic signed [IW:0] err;

  always_comb begin
    // ****************************************
    // derived values
    // ****************************************
    // off conditions
    enabled = ch.en_pin && ch.target[TGT_EN] && (ch.target[TGT_W-1:0] != '0);
    work    = IW'(ch.target[TGT_W-1:0]) + IW'(ch.offset[TGT_W-1:0]) + q.dval;
    step_len = {8'h00, ch.presc[PRE_N_LSB +: PRE_W]} + 16'h0001;
    m1       = {8'h00, ch.presc[PRE_M_LSB +: PRE_W]} + 16'h0001;
    step_per = 16'(step_len * m1);
    err = $signed({1'b0, IW'(ch.isense)}) - $signed({1'b0, work});
    lim = q.clamp_act ? CLAMP_LIM : NORM_LIM;
    next_q = q;
    next_q.pwm_start = 1'b0;
    next_q.miss = 1'b0;

    // ****************************************
    // dither generator
    // ****************************************
    // triangular dither
    // pwm start remembered until a step boundary in idle or wait, or the end of the down slope
    if (q.pwm_start) next_q.pwm_seen = 1'b1;
    if (q.pre_cnt + 16'h0001 >= step_per) begin
      next_q.pre_cnt = '0;
      unique case (q.dst)
        SCL_D_IDLE, SCL_D_WAIT: begin
          // new settings only at period end
          next_q.dit_cfg = ch.dither;
          next_q.dval = '0;
          // free run or wait for pwm
          if (ch.dither[DIT_EN] && (!ch.dither[DIT_ALIGN] || q.pwm_start || q.pwm_seen)) begin
            next_q.dst = SCL_D_UP;
            next_q.pwm_seen = 1'b0;
            next_q.dval = IW'(ch.dither[DIT_INC_LSB +: DIT_INC_W]);
            next_q.step_cnt = 5'd1;
          end else begin
            next_q.dst = ch.dither[DIT_EN] ? SCL_D_WAIT : SCL_D_IDLE;
            if (!ch.dither[DIT_EN]) next_q.pwm_seen = 1'b0;
          end
        end
        SCL_D_UP: begin
          if (q.step_cnt >= 5'(2 * q.dit_cfg[DIT_STEP_LSB +: DIT_STEP_W] - 1)) begin
            next_q.dst = SCL_D_DOWN;
            next_q.step_cnt = '0;
          end else begin
            next_q.step_cnt = q.step_cnt + 5'd1;
          end
          next_q.dval = q.dval + IW'(q.dit_cfg[DIT_INC_LSB +: DIT_INC_W]);
        end
        SCL_D_DOWN: begin
          next_q.dval = q.dval - IW'(q.dit_cfg[DIT_INC_LSB +: DIT_INC_W]);
          next_q.step_cnt = q.step_cnt + 5'd1;
          if (q.step_cnt + 5'd1 >= 5'(2 * q.dit_cfg[DIT_STEP_LSB +: DIT_STEP_W])) begin
            next_q.dst = SCL_D_WAIT;
            next_q.dval = '0;
            next_q.pwm_seen = 1'b0;
          end
        end
        default: next_q.dst = SCL_D_IDLE;
      endcase
    end else begin
      next_q.pre_cnt = q.pre_cnt + 16'h0001;
    end

    // ****************************************
    // controller and switch sequencing
    // ****************************************
    next_q.per_cnt = q.per_cnt + 16'h0001;
    if (!enabled) begin
      next_q.phase = SCL_OFF;
      next_q.integ = '0;
    end else begin
      unique case (q.phase)
        SCL_OFF: begin
          next_q.phase = SCL_DRIVE;
          next_q.pwm_start = 1'b1;
          next_q.per_cnt = '0;
        end
        SCL_DRIVE: begin
          next_q.integ = q.integ + err;
          if (q.integ > $signed({1'b0, q.thr})) next_q.phase = SCL_RECIRC;
        end
        default: begin
          next_q.integ = q.integ + err;
          if (q.integ <= 0) begin
            next_q.phase = SCL_DRIVE;
            next_q.integ = '0;
            next_q.pwm_start = 1'b1;
            next_q.per_cnt = '0;
            if ((q.per_cnt >> 4) < ch.period && q.thr < NORM_LIM) next_q.thr = q.thr + 20'd1;
            else if ((q.per_cnt >> 4) > ch.period && q.thr > 20'd1) next_q.thr = q.thr - 20'd1;
          end
        end
      endcase
      if (next_q.integ > $signed({1'b0, lim})) next_q.integ = $signed({1'b0, lim});
      else if (next_q.integ < -$signed({1'b0, lim})) next_q.integ = -$signed({1'b0, lim});
    end

    // ****************************************
    // setpoint change tracking
    // ****************************************
    if (ch.tgt_wr) begin
      next_q.miss_arm = 1'b1;
      next_q.miss_cnt = '0;
      next_q.clamp_act = ch.target[TGT_CLAMP];
    end else if (q.miss_arm && (err >= 0)) begin
      next_q.miss_arm = 1'b0;
      next_q.clamp_act = 1'b0;
    end else if (q.miss_arm && q.pwm_start) begin
      next_q.miss_cnt = q.miss_cnt + 4'd1;
      if (q.miss_cnt + 4'd1 >= MISS_CYC) begin
        next_q.miss = 1'b1;
        next_q.miss_arm = 1'b0;
      end
    end
    if (ch.tgt_wr) next_q.miss = 1'b0;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '{phase: SCL_OFF, dst: SCL_D_IDLE, thr: THR_RESET, default: '0};
    end else begin
      q <= next_q;
    end
  end

  assign ch.drive  = (q.phase == SCL_DRIVE) && enabled;
  assign ch.recirc = (q.phase == SCL_RECIRC) && enabled;
  assign ch.miss   = q.miss;
  assign ch.status = {q.phase, q.dst, 2'b00, q.dval[9:0]};
endmodule : scl_chan

// ==== scl_top.sv ====
// top: register file and two independent current loops
// Summary of operation
// - target register sets average channel current
// - offset trim corrects internal working target
// - target readback unaffected by offset trim
// - optional triangular dither added to target
// - step count sets steps per quarter wave
// - step time from two prescaler dividers
// - dither changes wait for period end
// - alignment bit low: dither runs freely
// - alignment bit high: period waits pwm start
// - dither period begins one step up
// - drive and recirculation switches alternate
// - integrator sums current minus target each cycle
// - cycle start: drive on, recirc off
// - integrator above threshold: drive off, recirc on
// - threshold tuned until period matches setting
// - integrator back to zero starts next cycle
// - clamp bit limits integrator after target change
// - clamp bit held until written or reset
// - target missed in eight cycles sets fault
// - each channel has its own loop
// - pin, enable bit or zero target: both off
// - drive and recirc never on together
`timescale 1ns/1ps
module scl_top
  import scl_pkg::*;
(
  input  wire logic                   clk,       // 40 MHz clock
  input  wire logic                   rst,       // async reset, high
  input  wire logic [AW-1:0]          addr,      // register index
  input  wire logic [DW-1:0]          wdata,     // write data
  input  wire logic                   wr,        // write strobe
  input  wire logic                   rd,        // read strobe
  output logic      [DW-1:0]          rdata,     // read data, next cycle
  input  wire logic                   en_pin,    // enable pin
  input  wire logic [NCH*TGT_W-1:0]   isense,    // measured current per channel
  output logic      [NCH-1:0]         drive,     // drive switch per channel
  output logic      [NCH-1:0]         recirc     // recirculation switch per channel
);
  typedef struct packed {
    logic [NCH-1:0][DW-1:0] target;
    logic [NCH-1:0][DW-1:0] dither;
    logic [NCH-1:0][DW-1:0] period;
    logic [NCH-1:0][DW-1:0] offset;
    logic [DW-1:0]          presc;
    logic [NCH-1:0]         fault;
    logic [DW-1:0]          rdata;
  } scl_top_s;

  scl_top_s q;
  scl_top_s next_q;
  logic [NCH-1:0]         miss;
  logic [NCH-1:0][DW-1:0] stat;
  logic [NCH-1:0]         tgt_wr;

  // ****************************************
  // channels
  // ****************************************
  // one loop per channel
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      scl_chan_if cif();
      assign cif.target = q.target[g];
      assign cif.dither = q.dither[g];
      assign cif.period = q.period[g];
      assign cif.offset = q.offset[g];
      assign cif.presc  = q.presc;
      assign cif.en_pin = en_pin;
      assign cif.tgt_wr = tgt_wr[g];
      assign cif.isense = isense[g*TGT_W +: TGT_W];
      assign drive[g]   = cif.drive;
      assign recirc[g]  = cif.recirc;
      assign miss[g]    = cif.miss;
      assign stat[g]    = cif.status;
      assign tgt_wr[g]  = wr && (addr == (OFS_TARGET + AW'(4 * g)));
      scl_chan u_chan (
        .clk (clk),
        .rst (rst),
        .ch  (cif.core)
      );
    end
  endgenerate

  // ****************************************
  // register file
  // ****************************************
  always_comb begin
    next_q = q;
    next_q.rdata = '0;
    for (int i = 0; i < NCH; i++) begin
      if (rd && addr == OFS_FAULT) next_q.fault[i] = 1'b0;
      if (miss[i]) next_q.fault[i] = 1'b1;
      if (wr) begin
        if (addr == OFS_TARGET + AW'(4 * i)) next_q.target[i] = wdata;
        if (addr == OFS_DITHER + AW'(4 * i)) next_q.dither[i] = wdata;
        if (addr == OFS_PERIOD + AW'(4 * i)) next_q.period[i] = wdata;
        if (addr == OFS_OFFSET + AW'(4 * i)) next_q.offset[i] = wdata;
      end
      if (!en_pin) next_q.target[i][TGT_EN] = 1'b0;
      if (rd) begin
        if (addr == OFS_TARGET + AW'(4 * i)) next_q.rdata = q.target[i];
        if (addr == OFS_DITHER + AW'(4 * i)) next_q.rdata = q.dither[i];
        if (addr == OFS_PERIOD + AW'(4 * i)) next_q.rdata = q.period[i];
        if (addr == OFS_OFFSET + AW'(4 * i)) next_q.rdata = q.offset[i];
      end
    end
    if (wr && addr == OFS_PRESC) next_q.presc = wdata;
    if (rd && addr == OFS_PRESC) next_q.rdata = q.presc;
    if (rd && addr == OFS_FAULT) next_q.rdata = {{(DW-NCH){1'b0}}, q.fault};
    if (rd && addr == OFS_CHSTAT) next_q.rdata = stat[0];
    if (rd && addr == OFS_CHSTAT + 4'h1) next_q.rdata = stat[1];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '{target: '{default: TARGET_RST}, dither: '{default: DITHER_RST},
             period: '{default: PERIOD_RST}, offset: '0, presc: PRESC_RST,
             fault: '0, rdata: '0};
    end else begin
      q <= next_q;
    end
  end

  assign rdata = q.rdata;
endmodule : scl_top

// ==== scl_assertions.sv ====
// checker: switch and register-port properties of the current loop
`timescale 1ns/1ps
module scl_checker
  import scl_pkg::*;
(
  input wire logic            clk,     // clock
  input wire logic            rst,     // async reset
  input wire logic [AW-1:0]   addr,    // register index
  input wire logic            wr,      // write strobe
  input wire logic            rd,      // read strobe
  input wire logic [DW-1:0]   rdata,   // read data
  input wire logic            en_pin,  // enable pin
  input wire logic [NCH-1:0]  drive,   // drive switches
  input wire logic [NCH-1:0]  recirc   // recirc switches
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_no_shoot : assert property ((drive & recirc) == '0)
    else $error("drive and recirc on together");
  a_pin_off : assert property (!en_pin && !$past(en_pin) |-> drive == '0 && recirc == '0)
    else $error("switch on with pin low");
  a_drive_needs_pin : assert property ($rose(drive[0]) |-> $past(en_pin))
    else $error("drive started with pin low");
  a_pin_clears_en : assert property (rd && !en_pin && !$past(en_pin) && (addr == OFS_TARGET || addr == 4'h4)
    |=> !rdata[TGT_EN])
    else $error("enable bit kept with pin low");
  a_recirc_after_drive : assert property ($rose(recirc[0]) |-> $past(drive[0]) || $past(drive[0], 2))
    else $error("recirc without prior drive");
  a_drive_after_recirc : assert property ($fell(recirc[0]) && en_pin && $past(en_pin) && !$past(wr)
    && !$past(wr, 2) |-> ##[0:2] drive[0])
    else $error("no drive after recirc");
  a_rdata_idle : assert property (!$past(rd) |-> rdata == '0)
    else $error("read data outside read slot");
  a_unmapped_zero : assert property ($past(rd) && $past(addr) >= 4'hc |-> rdata == '0)
    else $error("unmapped read not zero");
  a_reset_quiet : assert property ($fell(rst) |-> drive == '0 && recirc == '0)
    else $error("switch on after reset");
endmodule : scl_checker

bind scl_top scl_checker chk_u (.clk(clk), .rst(rst), .addr(addr), .wr(wr), .rd(rd), .rdata(rdata),
  .en_pin(en_pin), .drive(drive), .recirc(recirc));

// ==== scl_load.sv ====
// model: two solenoid loads turning switch states into sensed current
`timescale 1ns/1ps
module scl_load
  import scl_pkg::*;
(
  input  wire logic [0:0]          clk,     // clock
  input  wire logic                rst,     // reset
  input  wire logic [NCH-1:0]      drive,   // drive switches
  input  wire logic [NCH-1:0]      recirc,  // recirc switches
  output logic      [NCH*TGT_W-1:0] isense  // sensed current
);
  logic [TGT_W-1:0] cur [NCH];
  // rises while driven, slow decay freewheeling, fast decay when off
  always_ff @(posedge clk or posedge rst) begin
    for (int i = 0; i < NCH; i++) begin
      if (rst) cur[i] <= '0;
      else if (drive[i]) cur[i] <= (cur[i] > 11'h7f0) ? 11'h7ff : cur[i] + 11'h004;
      else if (recirc[i]) cur[i] <= (cur[i] == '0) ? '0 : cur[i] - 11'h001;
      else cur[i] <= (cur[i] < 11'h008) ? '0 : cur[i] - 11'h008;
    end
  end
  assign isense = {cur[1], cur[0]};
endmodule : scl_load

// ==== solenoid_current_loop_tb.sv ====
// testbench: register port and switch behaviour of the current loop
`timescale 1ns/1ps
`define CHECK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin fail_count++; \
  $display("unexpected %s expected %h seen %h", nm, exp, got); end end
module solenoid_current_loop_tb;
  import scl_pkg::*;
  logic                 clk = 0, rst = 1, wr = 0, rd = 0, en_pin = 1;
  logic [AW-1:0]        addr = '0;
  logic [DW-1:0]        wdata = '0, rdata;
  logic [NCH*TGT_W-1:0] isense;
  logic [NCH-1:0]       drive, recirc, pd = '0, pr = '0;
  int                   fail_count = 0, samples_checked = 0;
  int                   rise_d[NCH] = '{0, 0}, rise_r[NCH] = '{0, 0};

  scl_top dut_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .en_pin(en_pin), .isense(isense), .drive(drive), .recirc(recirc));
  scl_load load_u (.clk(clk), .rst(rst), .drive(drive), .recirc(recirc), .isense(isense));

  initial forever #12.5 clk = ~clk;
  always @(posedge clk) begin
    for (int i = 0; i < NCH; i++) begin
      if (drive[i] && !pd[i]) rise_d[i]++;
      if (recirc[i] && !pr[i]) rise_r[i]++;
    end
    pd <= drive;
    pr <= recirc;
  end

  task automatic tally_and_finish;
    if (fail_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic check_rd(input logic [AW-1:0] a, input logic [DW-1:0] e, input string nm);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 `CHECK(nm, e, rdata)
  endtask : check_rd

  task automatic check_rd_mask(input logic [AW-1:0] a, input logic [DW-1:0] m, input logic [DW-1:0] e,
                               input string nm);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 `CHECK(nm, e, rdata & m)
  endtask : check_rd_mask

  task automatic wait_starts(input int c, input int n);
    int base;
    base = rise_d[c];
    for (int i = 0; i < 15000 && rise_d[c] < base + n; i++) @(posedge clk);
    `CHECK("pwm starts", 1'b1, rise_d[c] >= base + n)
  endtask : wait_starts

  task automatic t_reset_values;
    check_rd(OFS_TARGET, TARGET_RST, "target");
    check_rd(OFS_DITHER, DITHER_RST, "dither");
    check_rd(OFS_PERIOD, PERIOD_RST, "period");
    check_rd(OFS_PRESC, PRESC_RST, "prescaler");
    check_rd(OFS_FAULT, 16'h0000, "fault");
  endtask : t_reset_values

  task automatic t_regulate;
    wr_reg(OFS_OFFSET, 16'h0010);
    wr_reg(OFS_TARGET, 16'h8100);
    check_rd(OFS_TARGET, 16'h8100, "target readback");
    wait_starts(0, 3);
    `CHECK("recirc phases", 1'b1, rise_r[0] > 0)
    `CHECK("idle channel", 0, rise_d[1])
    check_rd(OFS_TARGET, 16'h8100, "target after trim");
    check_rd(OFS_FAULT, 16'h0000, "fault reached");
  endtask : t_regulate

  task automatic t_clamp;
    wr_reg(4'h4, 16'hc080);
    wait_starts(1, 3);
    check_rd(4'h4, 16'hc080, "clamp bit");
  endtask : t_clamp

  task automatic t_dither;
    // steps 8 times increment 4 stays under limit
    wr_reg(OFS_PRESC, 16'h0103);
    wr_reg(OFS_DITHER, 16'hc088);
    check_rd(OFS_DITHER, 16'hc088, "dither aligned");
    wait_starts(0, 3);
    wr_reg(OFS_DITHER, 16'h8088);
    wait_starts(0, 3);
    wr_reg(OFS_DITHER, 16'h0000);
    wait_starts(0, 2);
    check_rd_mask(OFS_CHSTAT, 16'h3fff, 16'h0000, "dither settled");
  endtask : t_dither

  task automatic t_pin_off;
    @(posedge clk);
    en_pin <= 1'b0;
    repeat (3) @(posedge clk);
    #1 `CHECK("switches pin low", 4'h0, {drive, recirc})
    check_rd(OFS_TARGET, 16'h0100, "enable cleared ch0");
    check_rd(4'h4, 16'h4080, "enable cleared ch1");
    @(posedge clk);
    en_pin <= 1'b1;
    repeat (100) @(posedge clk);
    #1 `CHECK("switches after pin", 4'h0, {drive, recirc})
  endtask : t_pin_off

  task automatic t_zero_target;
    wr_reg(OFS_TARGET, 16'h8100);
    wait_starts(0, 2);
    wr_reg(OFS_TARGET, 16'h8000);
    repeat (100) @(posedge clk);
    #1 `CHECK("zero target", 2'b00, {drive[0], recirc[0]})
  endtask : t_zero_target

  task automatic t_unmapped;
    wr_reg(4'hc, 16'h1234);
    check_rd(4'hc, 16'h0000, "unmapped");
  endtask : t_unmapped

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset_values();
    t_regulate();
    t_clamp();
    t_dither();
    t_pin_off();
    t_zero_target();
    t_unmapped();
    tally_and_finish();
  end

  initial begin
    #2_400_000;
    fail_count++;
    tally_and_finish();
  end
endmodule : solenoid_current_loop_tb
